// *** verilog/ifp_defs.vh ***
`ifndef IFP_DEFS_VH
`define IFP_DEFS_VH
`define IFP_PC_W 21
`define IFP_PC_RESET 21'h000002
`define IFP_PC_STEP 21'h000002
`define IFP_PH_ONE 2'h0
`define IFP_PH_TWO 2'h1
`define IFP_PH_THREE 2'h2
`define IFP_PH_FOUR 2'h3
`define IFP_C_NOP 4'h0
`define IFP_C_LIT_TO_W 4'h1
`define IFP_C_RET_LIT 4'h2
`define IFP_C_W_TO_FILE 4'h3
`define IFP_C_FILE_TO_W 4'h4
`define IFP_C_ADD_W 4'h5
`define IFP_C_TEST_SKIP 4'h6
`define IFP_C_FILE_MOVE 4'h7
`define IFP_C_ABS_JUMP 4'h8
`define IFP_C_ABS_CALL 4'h9
`define IFP_C_LOAD_PTR 4'ha
`define IFP_C_REL_BRANCH 4'hb
`define IFP_C_TAIL 4'hc
`define IFP_OP_LIT_TO_W 8'h0e
`define IFP_OP_RET_LIT 8'h0c
`define IFP_OP_ABS_JUMP 8'hef
`define IFP_OP_ABS_CALL 8'hec
`define IFP_OP_LOAD_PTR 8'hee
`define IFP_OP_W_TO_FILE 7'h37
`define IFP_OP_FILE_TO_W 7'h28
`define IFP_OP_TEST_SKIP 7'h33
`define IFP_OP_ADD_W 6'h09
`define IFP_OP_REL_BRANCH 5'h1a
`define IFP_OP_FILE_MOVE 4'hc
`define IFP_OP_TAIL 4'hf
`define IFP_ADDR_PC_LOW 12'hff9
`define IFP_ADDR_PC_HIGH 12'hffa
`define IFP_ADDR_PC_UPPER 12'hffb
`define IFP_BANK_ACCESS_HI 4'hf
`define IFP_BANK_ACCESS_LO 4'h0
`endif

// *** verilog/ifp_phase_gen.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ifp_defs.vh"
module ifp_phase_gen (
	input wire sys_clk,
	input wire rst_b,
	output reg [1:0] phase_r,
	output reg phase_one,
	output reg phase_two,
	output reg phase_three,
	output reg phase_four
);
	wire [1:0] phase_nxt;

	// The phase count wraps every four clocks.
	assign phase_nxt = phase_r + 2'h1;

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_r <= `IFP_PH_ONE;
			phase_one <= 1'b1;
			phase_two <= 1'b0;
			phase_three <= 1'b0;
			phase_four <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			phase_one <= (phase_nxt == `IFP_PH_ONE);
			phase_two <= (phase_nxt == `IFP_PH_TWO);
			phase_three <= (phase_nxt == `IFP_PH_THREE);
			phase_four <= (phase_nxt == `IFP_PH_FOUR);
		end
	end
endmodule // ifp_phase_gen
`default_nettype wire

// *** verilog/ifp_word_decode.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ifp_defs.vh"
module ifp_word_decode (
	input wire [15:0] word,
	input wire word_valid,
	output wire [3:0] word_class
);
	function [3:0] ifp_classify;
		input [15:0] w;
		begin
			if (w[15:8] == `IFP_OP_ABS_JUMP)
				ifp_classify = `IFP_C_ABS_JUMP;
			else if (w[15:8] == `IFP_OP_ABS_CALL)
				ifp_classify = `IFP_C_ABS_CALL;
			else if (w[15:8] == `IFP_OP_LOAD_PTR)
				ifp_classify = `IFP_C_LOAD_PTR;
			else if (w[15:12] == `IFP_OP_FILE_MOVE)
				ifp_classify = `IFP_C_FILE_MOVE;
			else if (w[15:12] == `IFP_OP_TAIL)
				ifp_classify = `IFP_C_TAIL;
			else if (w[15:8] == `IFP_OP_LIT_TO_W)
				ifp_classify = `IFP_C_LIT_TO_W;
			else if (w[15:8] == `IFP_OP_RET_LIT)
				ifp_classify = `IFP_C_RET_LIT;
			else if (w[15:9] == `IFP_OP_W_TO_FILE)
				ifp_classify = `IFP_C_W_TO_FILE;
			else if (w[15:9] == `IFP_OP_FILE_TO_W)
				ifp_classify = `IFP_C_FILE_TO_W;
			else if (w[15:9] == `IFP_OP_TEST_SKIP)
				ifp_classify = `IFP_C_TEST_SKIP;
			else if (w[15:10] == `IFP_OP_ADD_W)
				ifp_classify = `IFP_C_ADD_W;
			else if (w[15:11] == `IFP_OP_REL_BRANCH)
				ifp_classify = `IFP_C_REL_BRANCH;
			else
				ifp_classify = `IFP_C_NOP;
		end
	endfunction

	// A flushed slot always decodes as a no-operation.
	assign word_class = word_valid ? ifp_classify(word) : `IFP_C_NOP;
endmodule // ifp_word_decode
`default_nettype wire

// *** verilog/ifp_core.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ifp_defs.vh"
module ifp_core #(
	parameter PC_W = `IFP_PC_W
) (
	input wire sys_clk,
	input wire rst_b,
	output wire phase_one,
	output wire phase_two,
	output wire phase_three,
	output wire phase_four,
	output reg [PC_W-1:0] prog_addr_r,
	output reg prog_fetch_r,
	input wire [15:0] prog_data,
	output reg [11:0] dmem_addr_r,
	output reg dmem_rd_r,
	input wire [7:0] dmem_rdata,
	output reg dmem_wr_r,
	output reg [7:0] dmem_wdata_r,
	input wire [PC_W-1:0] ret_addr,
	output reg ret_pop_r,
	output reg call_push_r,
	output reg [PC_W-1:0] push_addr_r,
	output reg ptr_load_r,
	output reg [1:0] ptr_sel_r,
	output reg [11:0] ptr_value_r,
	output reg [7:0] working_register_r,
	output reg [15:0] instruction_latch_r,
	output reg [PC_W-1:0] pc_r,
	output reg [7:0] pc_high_latch_r,
	output reg [4:0] pc_upper_latch_r
);
	wire [1:0] phase;
	wire [3:0] cls;
	reg ir_valid_r;
	reg [11:0] ex_addr_r;
	reg ex_sfr_r;
	reg [3:0] tw_kind_r;
	reg [7:0] tw_op_r;
	reg [7:0] tw_data_r;
	reg ld_pc_r;
	reg [PC_W-1:0] ld_val_r;
	reg kill_r;
	reg [PC_W-1:0] pc_fetch_nxt;
	reg [7:0] sfr_rd;
	reg [7:0] opnd;
	reg [8:0] sum;
	reg [7:0] w_nxt;
	reg wr_en;
	reg [11:0] wr_addr;
	reg [7:0] wr_data;
	reg ld_pc_nxt;
	reg [PC_W-1:0] ld_val_nxt;
	reg kill_nxt;
	reg [3:0] tw_kind_nxt;
	reg [7:0] tw_op_nxt;
	reg [7:0] tw_data_nxt;
	reg [7:0] lath_nxt;
	reg [4:0] latu_nxt;
	reg push_nxt;
	reg pop_nxt;
	reg ptr_nxt;
	reg [PC_W-1:0] ret_here;
	reg [PC_W-1:0] br_off;
	reg [11:0] rd_addr_nxt;
	reg rd_need;

	ifp_phase_gen u_phase (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.phase_r(phase),
		.phase_one(phase_one),
		.phase_two(phase_two),
		.phase_three(phase_three),
		.phase_four(phase_four)
	);

	ifp_word_decode u_decode (
		.word(instruction_latch_r),
		.word_valid(ir_valid_r),
		.word_class(cls)
	);

	function ifp_is_sfr;
		input [11:0] a;
		begin
			ifp_is_sfr = (a == `IFP_ADDR_PC_LOW) || (a == `IFP_ADDR_PC_HIGH) ||
				(a == `IFP_ADDR_PC_UPPER);
		end
	endfunction

	// Operand address for the executing word, formed during phase one.
	always @* begin
		rd_need = 1'b0;
		rd_addr_nxt = {(instruction_latch_r[8] ? `IFP_BANK_ACCESS_HI : `IFP_BANK_ACCESS_LO),
			instruction_latch_r[7:0]};
		case (cls)
			`IFP_C_FILE_TO_W, `IFP_C_ADD_W, `IFP_C_TEST_SKIP: begin
				rd_need = 1'b1;
			end
			`IFP_C_FILE_MOVE: begin
				rd_need = 1'b1;
				rd_addr_nxt = instruction_latch_r[11:0];
			end
			default: begin
				rd_need = 1'b0;
			end
		endcase
	end

	// Core-held registers seen at data addresses.
	always @* begin
		case (ex_addr_r)
			`IFP_ADDR_PC_LOW: sfr_rd = pc_r[7:0];
			`IFP_ADDR_PC_HIGH: sfr_rd = pc_high_latch_r;
			`IFP_ADDR_PC_UPPER: sfr_rd = {3'h0, pc_upper_latch_r};
			default: sfr_rd = 8'h00;
		endcase
	end

	// Execute decisions, taken at the end of phase three.
	always @* begin
		opnd = ex_sfr_r ? sfr_rd : dmem_rdata;
		sum = {1'b0, opnd} + {1'b0, working_register_r};
		w_nxt = working_register_r;
		wr_en = 1'b0;
		wr_addr = ex_addr_r;
		wr_data = working_register_r;
		ld_pc_nxt = 1'b0;
		ld_val_nxt = pc_r;
		kill_nxt = 1'b0;
		tw_kind_nxt = `IFP_C_NOP;
		tw_op_nxt = tw_op_r;
		tw_data_nxt = tw_data_r;
		lath_nxt = pc_high_latch_r;
		latu_nxt = pc_upper_latch_r;
		push_nxt = 1'b0;
		pop_nxt = 1'b0;
		ptr_nxt = 1'b0;
		ret_here = pc_r - `IFP_PC_STEP;
		br_off = {{(PC_W-12){instruction_latch_r[10]}}, instruction_latch_r[10:0], 1'b0};
		case (cls)
			`IFP_C_LIT_TO_W: begin
				w_nxt = instruction_latch_r[7:0];
			end
			`IFP_C_RET_LIT: begin
				w_nxt = instruction_latch_r[7:0];
				pop_nxt = 1'b1;
				ld_pc_nxt = 1'b1;
				ld_val_nxt = {ret_addr[PC_W-1:1], 1'b0};
				kill_nxt = 1'b1;
			end
			`IFP_C_W_TO_FILE: begin
				wr_en = 1'b1;
			end
			`IFP_C_FILE_TO_W: begin
				w_nxt = opnd;
				if (ex_addr_r == `IFP_ADDR_PC_LOW) begin
					lath_nxt = pc_r[15:8];
					latu_nxt = pc_r[20:16];
				end
			end
			`IFP_C_ADD_W: begin
				if (instruction_latch_r[9]) begin
					wr_en = 1'b1;
					wr_data = sum[7:0];
				end else begin
					w_nxt = sum[7:0];
				end
			end
			`IFP_C_TEST_SKIP: begin
				kill_nxt = (opnd == 8'h00);
			end
			`IFP_C_FILE_MOVE, `IFP_C_ABS_JUMP, `IFP_C_ABS_CALL, `IFP_C_LOAD_PTR: begin
				tw_kind_nxt = cls;
				tw_op_nxt = instruction_latch_r[7:0];
				tw_data_nxt = opnd;
			end
			`IFP_C_REL_BRANCH: begin
				ld_pc_nxt = 1'b1;
				ld_val_nxt = ret_here + br_off;
				kill_nxt = 1'b1;
			end
			`IFP_C_TAIL: begin
				case (tw_kind_r)
					`IFP_C_FILE_MOVE: begin
						wr_en = 1'b1;
						wr_addr = instruction_latch_r[11:0];
						wr_data = tw_data_r;
					end
					`IFP_C_ABS_JUMP, `IFP_C_ABS_CALL: begin
						ld_pc_nxt = 1'b1;
						ld_val_nxt = {instruction_latch_r[11:0], tw_op_r, 1'b0};
						kill_nxt = 1'b1;
						push_nxt = (tw_kind_r == `IFP_C_ABS_CALL);
					end
					`IFP_C_LOAD_PTR: begin
						ptr_nxt = 1'b1;
					end
					default: begin
						// Reached without its first word: nothing happens.
						w_nxt = working_register_r;
					end
				endcase
			end
			default: begin
				w_nxt = working_register_r;
			end
		endcase
		if (wr_en && (wr_addr == `IFP_ADDR_PC_LOW)) begin
			ld_pc_nxt = 1'b1;
			ld_val_nxt = {pc_upper_latch_r, pc_high_latch_r, wr_data[7:1], 1'b0};
			kill_nxt = 1'b1;
		end
		if (wr_en && (wr_addr == `IFP_ADDR_PC_HIGH))
			lath_nxt = wr_data;
		if (wr_en && (wr_addr == `IFP_ADDR_PC_UPPER))
			latu_nxt = wr_data[4:0];
	end

	// Next fetch address: a pending load wins over sequential flow.
	always @* begin
		pc_fetch_nxt = ld_pc_r ? ld_val_r : pc_r;
		pc_fetch_nxt[0] = 1'b0;
	end

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			prog_addr_r <= {PC_W{1'b0}};
			prog_fetch_r <= 1'b1;
			pc_r <= `IFP_PC_RESET;
			instruction_latch_r <= 16'h0000;
			ir_valid_r <= 1'b0;
			ex_addr_r <= 12'h000;
			ex_sfr_r <= 1'b0;
			dmem_addr_r <= 12'h000;
			dmem_rd_r <= 1'b0;
			dmem_wr_r <= 1'b0;
			dmem_wdata_r <= 8'h00;
			working_register_r <= 8'h00;
			pc_high_latch_r <= 8'h00;
			pc_upper_latch_r <= 5'h00;
			tw_kind_r <= `IFP_C_NOP;
			tw_op_r <= 8'h00;
			tw_data_r <= 8'h00;
			ld_pc_r <= 1'b0;
			ld_val_r <= {PC_W{1'b0}};
			kill_r <= 1'b0;
			ret_pop_r <= 1'b0;
			call_push_r <= 1'b0;
			push_addr_r <= {PC_W{1'b0}};
			ptr_load_r <= 1'b0;
			ptr_sel_r <= 2'h0;
			ptr_value_r <= 12'h000;
		end else begin
			ret_pop_r <= 1'b0;
			call_push_r <= 1'b0;
			ptr_load_r <= 1'b0;
			dmem_rd_r <= 1'b0;
			dmem_wr_r <= 1'b0;
			prog_fetch_r <= 1'b0;
			case (phase)
				`IFP_PH_ONE: begin
					ex_addr_r <= rd_addr_nxt;
					ex_sfr_r <= ifp_is_sfr(rd_addr_nxt);
					dmem_addr_r <= rd_addr_nxt;
					dmem_rd_r <= rd_need && !ifp_is_sfr(rd_addr_nxt);
				end
				`IFP_PH_TWO: begin
					dmem_rd_r <= 1'b0;
				end
				`IFP_PH_THREE: begin
					working_register_r <= w_nxt;
					pc_high_latch_r <= lath_nxt;
					pc_upper_latch_r <= latu_nxt;
					tw_kind_r <= tw_kind_nxt;
					tw_op_r <= tw_op_nxt;
					tw_data_r <= tw_data_nxt;
					ld_pc_r <= ld_pc_nxt;
					ld_val_r <= ld_val_nxt;
					kill_r <= kill_nxt;
					dmem_addr_r <= wr_addr;
					dmem_wdata_r <= wr_data;
					dmem_wr_r <= wr_en && !ifp_is_sfr(wr_addr);
					ret_pop_r <= pop_nxt;
					call_push_r <= push_nxt;
					push_addr_r <= ret_here;
					ptr_load_r <= ptr_nxt;
					ptr_sel_r <= tw_op_r[5:4];
					ptr_value_r <= {tw_op_r[3:0], instruction_latch_r[7:0]};
				end
				`IFP_PH_FOUR: begin
					instruction_latch_r <= prog_data;
					ir_valid_r <= !kill_r;
					prog_addr_r <= pc_fetch_nxt;
					pc_r <= pc_fetch_nxt + `IFP_PC_STEP;
					prog_fetch_r <= 1'b1;
					ld_pc_r <= 1'b0;
					kill_r <= 1'b0;
				end
				default: begin
					prog_fetch_r <= 1'b0;
				end
			endcase
		end
	end
endmodule // ifp_core
`default_nettype wire

// *** dv/ifp_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ifp_mem_model (
	input wire logic sys_clk,
	input wire logic [20:0] prog_addr_r,
	output logic [15:0] prog_data,
	input wire logic [11:0] dmem_addr_r,
	input wire logic dmem_rd_r,
	input wire logic dmem_wr_r,
	input wire logic [7:0] dmem_wdata_r,
	output logic [7:0] dmem_rdata,
	input wire logic call_push_r,
	input wire logic [20:0] push_addr_r,
	output logic [20:0] ret_addr
);
	logic [15:0] prog [0:63];
	logic [7:0] dmem [0:255];
	initial begin
		for (int i = 0; i < 256; i++) begin
			dmem[i] = 8'ha5;
			if (i < 64)
				prog[i] = 16'h0000;
		end
		dmem_rdata = 8'h00;
		ret_addr = 21'h000000;
	end
	// Bit zero of the byte address only picks a lane, so a word sits at an even address.
	assign prog_data = prog[prog_addr_r[6:1]];
	// Read data is valid only after a read strobe; otherwise it flips every cycle.
	always @(posedge sys_clk) begin
		dmem_rdata <= dmem_rd_r ? dmem[dmem_addr_r[7:0]] : ~dmem_rdata;
		if (dmem_wr_r)
			dmem[dmem_addr_r[7:0]] <= dmem_wdata_r;
		if (call_push_r)
			ret_addr <= push_addr_r;
	end
endmodule // ifp_mem_model
`default_nettype wire

// *** dv/ifp_core_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module ifp_core_props #(
	parameter PC_W = 21
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic phase_one,
	input wire logic phase_two,
	input wire logic phase_three,
	input wire logic phase_four,
	input wire logic [PC_W-1:0] prog_addr_r,
	input wire logic prog_fetch_r,
	input wire logic [PC_W-1:0] pc_r,
	input wire logic dmem_rd_r,
	input wire logic dmem_wr_r,
	input wire logic [15:0] instruction_latch_r
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_rest;
		phase_two ##1 phase_three ##1 phase_four ##1 phase_one;
	endsequence
	sequence s_quiet;
		!(dmem_rd_r || dmem_wr_r) [*4];
	endsequence
	a_phase_order: assert property (phase_one |=> s_rest)
		else $error("phase order broken");
	a_phase_hot: assert property ($onehot({phase_one, phase_two, phase_three, phase_four}))
		else $error("phases not one-hot");
	a_fetch_phase: assert property (prog_fetch_r == phase_one)
		else $error("fetch pulse outside phase one");
	a_addr_holds: assert property (!phase_one |-> $stable(prog_addr_r))
		else $error("fetch address moved mid cycle");
	a_pc_lead: assert property (phase_two |-> pc_r == prog_addr_r + 2)
		else $error("pc not two ahead of fetch");
	a_addr_even: assert property (prog_addr_r[0] == 1'b0 && pc_r[0] == 1'b0)
		else $error("odd program address");
	a_read_phase: assert property (dmem_rd_r |-> phase_two)
		else $error("operand read outside phase two");
	a_write_phase: assert property (dmem_wr_r |-> phase_four)
		else $error("result write outside phase four");
	a_latch_phase: assert property (instruction_latch_r != $past(instruction_latch_r) |-> phase_one)
		else $error("latch changed outside phase one");
	a_empty_start: assert property ($rose(rst_b) |-> s_quiet)
		else $error("execution in first cycle");
endmodule // ifp_core_props
bind ifp_core ifp_core_props #(.PC_W(PC_W)) u_props (.sys_clk(sys_clk), .rst_b(rst_b),
	.phase_one(phase_one), .phase_two(phase_two), .phase_three(phase_three), .phase_four(phase_four),
	.prog_addr_r(prog_addr_r), .prog_fetch_r(prog_fetch_r), .pc_r(pc_r), .dmem_rd_r(dmem_rd_r),
	.dmem_wr_r(dmem_wr_r), .instruction_latch_r(instruction_latch_r));
`default_nettype wire

// *** dv/ifp_core_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module ifp_core_tb;
	logic sys_clk, rst_b, ph1, rd, wr, push, pop, pld;
	logic [1:0] psel;
	logic [11:0] pval;
	logic [7:0] lath;
	int n_pop = 0;
	logic [13:0] ptr_seen = 14'h0000;
	logic [20:0] pa, pc, ra, psh;
	logic [15:0] pd;
	logic [11:0] da;
	logic [7:0] rdat, wdat, w;
	int error_cnt, n_tests;
	logic [15:0] pgm [0:37] = '{16'h0e05, 16'h6e10, 16'h0e00, 16'h6e11, 16'h6611, 16'hc010, 16'hf012,
		16'hc010, 16'hf013, 16'h0e07, 16'h2610, 16'hef0e, 16'hf000, 16'h0e99, 16'hd001, 16'h0e98,
		16'h6e15, 16'hec20, 16'hf000, 16'h6e14, 16'h0e01, 16'h6ffa, 16'h51f9, 16'h6e16, 16'hee12, 16'hf034,
		16'hd7ff,
		16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0e05, 16'h27f9, 16'h0c11, 16'h0c22, 16'h0c3c, 16'h0c3c};
	logic [15:0] rows [0:6] = '{16'h100c, 16'h1100, 16'h12a5, 16'h1305, 16'h143c, 16'h1507, 16'h1630};
	ifp_core u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .phase_one(ph1), .phase_two(), .phase_three(),
		.phase_four(), .prog_addr_r(pa), .prog_fetch_r(), .prog_data(pd), .dmem_addr_r(da),
		.dmem_rd_r(rd), .dmem_rdata(rdat), .dmem_wr_r(wr), .dmem_wdata_r(wdat), .ret_addr(ra),
		.ret_pop_r(pop), .call_push_r(push), .push_addr_r(psh), .ptr_load_r(pld), .ptr_sel_r(psel),
		.ptr_value_r(pval), .working_register_r(w), .instruction_latch_r(), .pc_r(pc),
		.pc_high_latch_r(lath), .pc_upper_latch_r());
	// Counts return pulses and keeps the last pointer load.
	always @(posedge sys_clk) begin
		if (pop)
			n_pop <= n_pop + 1;
		if (pld)
			ptr_seen <= {psel, pval};
	end
	ifp_mem_model u_mem (.sys_clk(sys_clk), .prog_addr_r(pa), .prog_data(pd), .dmem_addr_r(da),
		.dmem_rd_r(rd), .dmem_wr_r(wr), .dmem_wdata_r(wdat), .dmem_rdata(rdat), .call_push_r(push),
		.push_addr_r(psh), .ret_addr(ra));
	task chk(input logic [20:0] got, input logic [20:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (2000) @(posedge sys_clk);
		error_cnt++;
		end_sim;
	end
	initial begin
		rst_b = 1'b0;
		error_cnt = 0;
		n_tests = 0;
		#1;
		for (int k = 0; k < 38; k++)
			u_mem.prog[k] = pgm[k];
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (300) @(posedge sys_clk);
		for (int k = 0; k < 7; k++)
			chk(u_mem.dmem[rows[k][15:8]], rows[k][7:0]);
		chk(w, 8'h30);
		chk(lath, 8'h00);
		chk(n_pop, 21'h000001);
		chk(ptr_seen, {2'h1, 12'h234});
		rst_b <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk(pa, 21'h000000);
		chk(pc, 21'h000002);
		chk(ph1, 1'b1);
		@(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		chk(pa, 21'h000002);
		end_sim;
	end
endmodule // ifp_core_tb
`default_nettype wire
